// *** core/ssa_pkg.sv ***
// package: constants of the service unit status and access register bank
// assumes: AXI4-Lite slave, 32-bit data, register index = byte address / 4
package ssa_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W = 14;
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_SERVICE_STATUS = 14'h0002;
  localparam logic [13:0] IDX_COMPONENT_ID_1 = 14'h1ff4;
  localparam logic [13:0] IDX_COMPONENT_ID_2 = 14'h1ff8;
  localparam logic [13:0] IDX_COMPONENT_ID_3 = 14'h1ffc;
  localparam logic [13:0] IDX_BOOT_CH0 = 14'h0010;
  localparam logic [13:0] IDX_BOOT_CH1 = 14'h0011;
  localparam logic [13:0] IDX_DEBUG_CH0 = 14'h0012;
  localparam logic [13:0] IDX_DEBUG_CH1 = 14'h0013;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h0014;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0015;
  localparam logic [13:0] IDX_CTRL = 14'h0016;
  localparam logic [13:0] IDX_SEC_STATUS = 14'h0017;
  // service status field positions
  localparam int unsigned POS_BOOT_DIRTY = 6;
  localparam int unsigned POS_DEBUG_DIRTY = 4;
  localparam int unsigned POS_HOT_PLUG = 3;
  localparam int unsigned POS_PROBE = 2;
  localparam int unsigned POS_ACCESS_LEVEL = 0;
  // debugger access level codes
  localparam logic [1:0] LEVEL_SERVICE_ONLY = 2'h0;
  localparam logic [1:0] LEVEL_NON_SECURE = 2'h1;
  localparam logic [1:0] LEVEL_FULL = 2'h2;
  // interrupt status bit positions
  localparam int unsigned IRQ_ACCESS_ERR = 0;
  localparam int unsigned IRQ_BOOT_WR = 1;
  localparam int unsigned IRQ_DEBUG_WR = 2;
  localparam int unsigned IRQ_PROBE = 3;
  localparam int unsigned IRQ_W = 4;
  // control register field positions
  localparam int unsigned POS_WP_EN = 0;
  // reset values
  localparam logic RST_HOT_PLUG = 1'b1;
  localparam logic RST_WP_EN = 1'b0;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  // identification fields, values arbitrary
  localparam logic [3:0] CID_CLASS = 4'h9;
  localparam logic [3:0] CID_ID_A = 4'h3;
  localparam logic [7:0] CID_ID_B = 8'h5a;
  localparam logic [7:0] CID_ID_C = 8'h7c;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssa_pkg

// *** core/ssa_top.sv ***
// file: service unit status and access register bank, AXI4-Lite slave
// assumes: one clock, master keeps AXI4-Lite valid/ready rules, prot[1]=1 non-secure
//
// Behaviour
// - registers of 8, 16 or 32 bits take atomic 8, 16 and 32 bit accesses.
// - each byte and half of a word and each byte of a half is written alone by its strobes.
// - write-protected registers ignore writes while write protection is engaged.
// - when the unit is non-secure, secure and non-secure accesses are both granted.
// - when secured, a non-secure write is dropped, a read gives 0 and an access error fires.
// - the security status bit reads 0 when secured and 1 when non-secured.
// - after reset the security attribution is loaded from the user configuration input.
// - the boot channel dirty flags are read-only to bus writes.
// - writing boot channel register x sets boot dirty flag x.
// - reading boot channel register x clears boot dirty flag x.
// - debug channel register x sets debug dirty flag x on write and clears it on read.
// - hot-plug clears when hot-plugging is disabled and only reset sets it again.
// - probe-detected sets when a probe is seen and only reset clears it.
// - access level 0 is service space only, 1 non-secure only, 2 secure and non-secure.
`timescale 1ns/1ps
`default_nettype none
module ssa_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // write address channel
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [15:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // write data channel
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // write response channel
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // read address channel
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [15:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // read data channel
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // device side inputs
  input wire logic CFG_NON_SECURE,
  input wire logic PROBE_PIN,
  input wire logic HOTPLUG_OFF_PIN,
  input wire logic [1:0] ACCESS_LEVEL,
  // outputs
  output logic ACCESS_ERR,
  output logic IRQ
);

  typedef struct packed {
    logic [1:0] probe_s;
    logic [1:0] hpoff_s;
    logic [1:0] level_s0;
    logic [1:0] level_s1;
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [13:0] aw_idx;
    logic aw_ns;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic access_err;
    logic irq;
    logic [1:0][31:0] boot_ch;
    logic [1:0][31:0] dbg_ch;
    logic [1:0] bdirty;
    logic [1:0] ddirty;
    logic hot_plug;
    logic probe;
    logic [1:0] level;
    logic non_secure;
    logic loaded;
    logic wp;
    logic [3:0] mask;
    logic [3:0] istat;
    logic rd_deny;
    logic [13:0] rd_idx;
  } ssa_state_s;

  ssa_state_s s_q;
  ssa_state_s s_d;
  logic wexec;
  logic wdeny;
  logic rexec;
  logic rdeny;
  logic [13:0] ridx;
  logic [3:0] ev;

  function automatic logic [13:0] ssa_idx(input logic [15:0] addr);
    ssa_idx = addr[15:2];
  endfunction : ssa_idx

  function automatic logic [31:0] ssa_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    ssa_merge = r;
  endfunction : ssa_merge

  always_comb begin
    s_d = s_q;
    s_d.access_err = 1'b0;
    ev = '0;
    s_d.probe_s = {s_q.probe_s[0], PROBE_PIN};
    s_d.hpoff_s = {s_q.hpoff_s[0], HOTPLUG_OFF_PIN};
    s_d.level_s0 = ACCESS_LEVEL;
    s_d.level_s1 = s_q.level_s0;
    s_d.level = s_q.level_s1;
    if (!s_q.loaded) begin
      s_d.non_secure = CFG_NON_SECURE;
      s_d.loaded = 1'b1;
    end
    if (s_q.hpoff_s[1]) begin
      s_d.hot_plug = 1'b0;
    end
    if (s_q.probe_s[1]) begin
      s_d.probe = 1'b1;
      ev[ssa_pkg::IRQ_PROBE] = !s_q.probe;
    end
    // channel acceptance
    if (AWVALID && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_idx = ssa_idx(AWADDR);
      s_d.aw_ns = AWPROT[1];
    end
    if (WVALID && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = WDATA;
      s_d.wstrb = WSTRB;
    end
    if (BREADY && s_q.bvalid) begin
      s_d.bvalid = 1'b0;
    end
    if (RREADY && s_q.rvalid) begin
      s_d.rvalid = 1'b0;
    end
    // read path first, so a write-side set wins over a read clear
    rexec = ARVALID && s_q.arready;
    ridx = ssa_idx(ARADDR);
    rdeny = !s_q.non_secure && ARPROT[1];
    if (rexec) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ssa_pkg::RESP_OKAY;
      s_d.rdata = '0;
      s_d.rd_deny = rdeny;
      s_d.rd_idx = ridx;
      if (rdeny) begin
        s_d.access_err = 1'b1;
        ev[ssa_pkg::IRQ_ACCESS_ERR] = 1'b1;
      end else begin
        case (ridx)
          ssa_pkg::IDX_SERVICE_STATUS: begin
            s_d.rdata[7:0] = {s_q.bdirty, s_q.ddirty, s_q.hot_plug, s_q.probe, s_q.level};
          end
          ssa_pkg::IDX_BOOT_CH0: begin
            s_d.rdata = s_q.boot_ch[0];
            s_d.bdirty[0] = 1'b0;
          end
          ssa_pkg::IDX_BOOT_CH1: begin
            s_d.rdata = s_q.boot_ch[1];
            s_d.bdirty[1] = 1'b0;
          end
          ssa_pkg::IDX_DEBUG_CH0: begin
            s_d.rdata = s_q.dbg_ch[0];
            s_d.ddirty[0] = 1'b0;
          end
          ssa_pkg::IDX_DEBUG_CH1: begin
            s_d.rdata = s_q.dbg_ch[1];
            s_d.ddirty[1] = 1'b0;
          end
          ssa_pkg::IDX_IRQ_STATUS: begin
            s_d.rdata[3:0] = s_q.istat;
            s_d.istat = '0;
          end
          ssa_pkg::IDX_IRQ_MASK: begin
            s_d.rdata[3:0] = s_q.mask;
          end
          ssa_pkg::IDX_CTRL: begin
            s_d.rdata[ssa_pkg::POS_WP_EN] = s_q.wp;
          end
          ssa_pkg::IDX_SEC_STATUS: begin
            s_d.rdata[0] = s_q.non_secure;
          end
          ssa_pkg::IDX_COMPONENT_ID_1: begin
            s_d.rdata[7:0] = {ssa_pkg::CID_CLASS, ssa_pkg::CID_ID_A};
          end
          ssa_pkg::IDX_COMPONENT_ID_2: begin
            s_d.rdata[7:0] = ssa_pkg::CID_ID_B;
          end
          ssa_pkg::IDX_COMPONENT_ID_3: begin
            s_d.rdata[7:0] = ssa_pkg::CID_ID_C;
          end
          default: begin
            s_d.rresp = ssa_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // write path once address and data are both held
    wexec = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    wdeny = !s_q.non_secure && s_q.aw_ns;
    if (wexec) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ssa_pkg::RESP_OKAY;
      if (wdeny) begin
        s_d.access_err = 1'b1;
        ev[ssa_pkg::IRQ_ACCESS_ERR] = 1'b1;
      end else begin
        case (s_q.aw_idx)
          ssa_pkg::IDX_SERVICE_STATUS, ssa_pkg::IDX_COMPONENT_ID_1,
          ssa_pkg::IDX_COMPONENT_ID_2, ssa_pkg::IDX_COMPONENT_ID_3,
          ssa_pkg::IDX_IRQ_STATUS: begin
            s_d.bresp = ssa_pkg::RESP_OKAY;
          end
          ssa_pkg::IDX_BOOT_CH0, ssa_pkg::IDX_BOOT_CH1: begin
            s_d.boot_ch[s_q.aw_idx[0]] = ssa_merge(s_q.boot_ch[s_q.aw_idx[0]], s_q.wdata,
                                                   s_q.wstrb);
            s_d.bdirty[s_q.aw_idx[0]] = 1'b1;
            ev[ssa_pkg::IRQ_BOOT_WR] = 1'b1;
          end
          ssa_pkg::IDX_DEBUG_CH0, ssa_pkg::IDX_DEBUG_CH1: begin
            s_d.dbg_ch[s_q.aw_idx[0]] = ssa_merge(s_q.dbg_ch[s_q.aw_idx[0]], s_q.wdata,
                                                  s_q.wstrb);
            s_d.ddirty[s_q.aw_idx[0]] = 1'b1;
            ev[ssa_pkg::IRQ_DEBUG_WR] = 1'b1;
          end
          ssa_pkg::IDX_IRQ_MASK: begin
            if (!s_q.wp) begin
              s_d.mask = 4'(ssa_merge({28'h0, s_q.mask}, s_q.wdata, s_q.wstrb));
            end
          end
          ssa_pkg::IDX_CTRL: begin
            if (s_q.wstrb[0]) begin
              s_d.wp = s_q.wdata[ssa_pkg::POS_WP_EN];
            end
          end
          ssa_pkg::IDX_SEC_STATUS: begin
            if (s_q.wstrb[0] && !s_q.aw_ns) begin
              s_d.non_secure = s_q.wdata[0];
            end
          end
          default: begin
            s_d.bresp = ssa_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // sticky status, set wins over read clear
    s_d.istat = s_d.istat | ev;
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
    s_d.irq = |(s_d.istat & s_d.mask);
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
      s_q.hot_plug <= ssa_pkg::RST_HOT_PLUG;
      s_q.wp <= ssa_pkg::RST_WP_EN;
      s_q.mask <= ssa_pkg::RST_IRQ_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign AWREADY = s_q.awready;
  assign WREADY = s_q.wready;
  assign ARREADY = s_q.arready;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;
  assign ACCESS_ERR = s_q.access_err;
  assign IRQ = s_q.irq;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  err_pulse_a: assert property (ACCESS_ERR |=> !ACCESS_ERR)
    else $error("access error longer than one cycle");
  err_with_resp_a: assert property (ACCESS_ERR |-> $rose(BVALID) || $rose(RVALID))
    else $error("access error without a fresh response");
  ns_read_zero_a: assert property ($rose(RVALID) && s_q.rd_deny |-> RDATA == 32'h0)
    else $error("denied read returned data");
  ns_granted_a: assert property (s_q.non_secure && s_q.loaded |=> !ACCESS_ERR)
    else $error("non-secure unit raised access error");
  boot_set_a: assert property (wexec && !wdeny && s_q.aw_idx == ssa_pkg::IDX_BOOT_CH1
    |=> s_q.bdirty[1] && s_q.istat[ssa_pkg::IRQ_BOOT_WR])
    else $error("boot dirty not set by write");
  boot_clr_a: assert property (rexec && !rdeny && ridx == ssa_pkg::IDX_BOOT_CH0
    && !(wexec && s_q.aw_idx == ssa_pkg::IDX_BOOT_CH0) |=> !s_q.bdirty[0])
    else $error("boot dirty not cleared by read");
  dbg_set_a: assert property (wexec && !wdeny && s_q.aw_idx == ssa_pkg::IDX_DEBUG_CH0
    |=> s_q.ddirty[0] ##1 s_q.ddirty[0] || $past(rexec))
    else $error("debug dirty not set by write");
  hot_plug_keep_a: assert property (!s_q.hot_plug |=> !s_q.hot_plug)
    else $error("hot-plug set again without reset");
  hot_plug_clear_a: assert property (s_q.hpoff_s[1] |=> !s_q.hot_plug)
    else $error("hot-plug not cleared");
  probe_keep_a: assert property (s_q.probe |=> s_q.probe)
    else $error("probe flag cleared");
  wp_mask_a: assert property (wexec && !wdeny && s_q.wp
    && s_q.aw_idx == ssa_pkg::IDX_IRQ_MASK |=> $stable(s_q.mask))
    else $error("protected mask changed");
  sec_read_a: assert property ($rose(RVALID) && !s_q.rd_deny
    && s_q.rd_idx == ssa_pkg::IDX_SEC_STATUS |-> RDATA == {31'h0, $past(s_q.non_secure)})
    else $error("security status mismatch");
  cid_zero_a: assert property ($rose(RVALID) && !s_q.rd_deny
    && s_q.rd_idx == ssa_pkg::IDX_COMPONENT_ID_2 |-> RDATA[31:8] == 24'h0)
    else $error("unused id bits non-zero");

  boot_write_c: cover property (wexec && s_q.aw_idx == ssa_pkg::IDX_BOOT_CH0 ##[1:20] rexec
    && ridx == ssa_pkg::IDX_BOOT_CH0);
  ns_denied_c: cover property (ACCESS_ERR && RVALID);
  irq_raised_c: cover property ($rose(IRQ));

endmodule : ssa_top
`default_nettype wire

// *** bench/ssa_bus_master.sv ***
// file: AXI4-Lite master model facing the register bank
// assumes: shares the slave clock; tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module ssa_bus_master (
  // clock
  input wire logic clk,
  // write channels
  output logic awvalid,
  input wire logic awready,
  output logic [15:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // read channels
  output logic arvalid,
  input wire logic arready,
  output logic [15:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // error pulse
  input wire logic err
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awprot, arprot} = 38'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
  end
  // released payload shows the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic ns, output logic [1:0] resp, output logic e);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    awprot <= {1'b0, ns, 1'b0};
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        bready <= 1'b0;
        resp = bresp;
        e = err;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic ns, output logic [31:0] d,
                    output logic [1:0] resp, output logic e);
    logic done;
    done = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    arprot <= {1'b0, ns, 1'b0};
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
        e = err;
        done = 1'b1;
      end
    end
  endtask : rd
endmodule : ssa_bus_master
`default_nettype wire

// *** bench/tb_service_unit_status_access.sv ***
// file: self-checking bench of the service unit register bank
// assumes: ssa_pkg, ssa_top and the bus master model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_service_unit_status_access;
  logic clock, arst_n, cfg_non_secure, probe_pin, hotplug_off, access_err, irq;
  logic [1:0] access_level, bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, dat;
  logic [3:0] wstrb;
  logic [13:0] ix;
  logic er;
  int bt;
  int mismatches;
  int compares;
  ssa_top u_dut (.CLOCK(clock), .ARST_N(arst_n), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .AWPROT(awprot), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
    .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .ARPROT(arprot), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .CFG_NON_SECURE(cfg_non_secure), .PROBE_PIN(probe_pin),
    .HOTPLUG_OFF_PIN(hotplug_off), .ACCESS_LEVEL(access_level), .ACCESS_ERR(access_err),
    .IRQ(irq));
  ssa_bus_master u_bm (.clk(clock), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .err(access_err));
  initial clock = 1'b0;
  always #5 clock = ~clock;
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [13:0] i, input logic [31:0] d, input logic [3:0] s,
                    input logic ns);
    u_bm.wr({i, 2'b00}, d, s, ns, rsp, er);
  endtask : wr
  task automatic rd(input logic [13:0] i, input logic ns);
    u_bm.rd({i, 2'b00}, ns, dat, rsp, er);
  endtask : rd
  task automatic do_reset(input logic nsec);
    cfg_non_secure <= nsec;
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset
  initial begin
    #500us;
    mismatches++;
    conclude();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    {arst_n, cfg_non_secure, probe_pin, hotplug_off, access_level} = 6'h00;
    do_reset(1'b0);
    rd(ssa_pkg::IDX_SEC_STATUS, 1'b0);
    chk("secured status", 32'h0, dat);
    rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b1);
    chk("ns read data", 32'h0, dat);
    chk("ns read err", 32'h1, er);
    chk("ns read resp", ssa_pkg::RESP_OKAY, rsp);
    wr(ssa_pkg::IDX_BOOT_CH0, 32'hffffffff, 4'hf, 1'b1);
    chk("ns write err", 32'h1, er);
    chk("ns write resp", ssa_pkg::RESP_OKAY, rsp);
    rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
    chk("status after ns write", 32'h08, dat);
    chk("secure read err", 32'h0, er);
    $display("test secure gating done");
    for (int l = 0; l < 3; l++) begin
      access_level <= l[1:0];
      repeat (5) @(posedge clock);
      rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
      chk("access level", 32'h08 | l, dat);
    end
    for (int i = 0; i < 4; i++) begin
      ix = ssa_pkg::IDX_BOOT_CH0 + 14'(i);
      bt = (i < 2) ? 6 + i : 2 + i;
      wr(ix, 32'h11223344, 4'hf, 1'b0);
      wr(ix, 32'h0000ee00, 4'h2, 1'b0);
      wr(ix, 32'h55660000, 4'hc, 1'b0);
      rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
      chk("dirty set", 32'h0a | (32'h1 << bt), dat);
      wr(ssa_pkg::IDX_SERVICE_STATUS, 32'h0, 4'hf, 1'b0);
      rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
      chk("dirty held", 32'h0a | (32'h1 << bt), dat);
      rd(ix, 1'b0);
      chk("channel data", 32'h5566ee44, dat);
      rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
      chk("dirty cleared", 32'h0a, dat);
    end
    $display("test channels done");
    rd(ssa_pkg::IDX_IRQ_STATUS, 1'b0);
    wr(ssa_pkg::IDX_CTRL, 32'h1, 4'h1, 1'b0);
    wr(ssa_pkg::IDX_IRQ_MASK, 32'hf, 4'hf, 1'b0);
    rd(ssa_pkg::IDX_IRQ_MASK, 1'b0);
    chk("mask protected", 32'h0, dat);
    wr(ssa_pkg::IDX_BOOT_CH1, 32'h5, 4'hf, 1'b0);
    rd(ssa_pkg::IDX_BOOT_CH1, 1'b0);
    chk("irq masked", 32'h0, irq);
    wr(ssa_pkg::IDX_CTRL, 32'h0, 4'h1, 1'b0);
    wr(ssa_pkg::IDX_IRQ_MASK, 32'h2, 4'hf, 1'b0);
    repeat (2) @(posedge clock);
    chk("irq raised", 32'h1, irq);
    rd(ssa_pkg::IDX_IRQ_STATUS, 1'b0);
    chk("irq status", 32'h2, dat);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, irq);
    $display("test protect and irq done");
    probe_pin <= 1'b1;
    hotplug_off <= 1'b1;
    repeat (5) @(posedge clock);
    probe_pin <= 1'b0;
    hotplug_off <= 1'b0;
    repeat (5) @(posedge clock);
    rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b0);
    chk("probe and hot plug", 32'h06, dat);
    wr(ssa_pkg::IDX_COMPONENT_ID_1, 32'hffffffff, 4'hf, 1'b0);
    chk("id1 write resp", ssa_pkg::RESP_OKAY, rsp);
    rd(ssa_pkg::IDX_COMPONENT_ID_1, 1'b0);
    chk("id1", {24'h0, ssa_pkg::CID_CLASS, ssa_pkg::CID_ID_A}, dat);
    rd(ssa_pkg::IDX_COMPONENT_ID_2, 1'b0);
    chk("id2", {24'h0, ssa_pkg::CID_ID_B}, dat);
    rd(ssa_pkg::IDX_COMPONENT_ID_3, 1'b0);
    chk("id3", {24'h0, ssa_pkg::CID_ID_C}, dat);
    rd(14'h0040, 1'b0);
    chk("unmapped resp", ssa_pkg::RESP_SLVERR, rsp);
    wr(14'h0040, 32'h0, 4'hf, 1'b0);
    chk("unmapped write resp", ssa_pkg::RESP_SLVERR, rsp);
    $display("test pins and ids done");
    do_reset(1'b1);
    rd(ssa_pkg::IDX_SEC_STATUS, 1'b1);
    chk("nonsecure status", 32'h1, dat);
    chk("ns granted err", 32'h0, er);
    rd(ssa_pkg::IDX_SERVICE_STATUS, 1'b1);
    chk("hot plug after reset", 32'h0a, dat);
    wr(ssa_pkg::IDX_DEBUG_CH0, 32'h00000077, 4'h1, 1'b1);
    chk("ns write err", 32'h0, er);
    rd(ssa_pkg::IDX_DEBUG_CH0, 1'b1);
    chk("ns write data", 32'h77, dat & 32'hff);
    $display("test nonsecure unit done");
    conclude();
  end
endmodule : tb_service_unit_status_access
`default_nettype wire
